// file: logic/qsfpi_pkg.sv
package qsfpi_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 21;
  localparam int unsigned PAGE_BYTES   = 256;
  localparam int unsigned PAGE_COUNT   = 8192;
  localparam int unsigned ARRAY_BYTES  = 2097152;
  localparam int unsigned SECTOR_BYTES = 4096;
  localparam int unsigned BLK32_BYTES  = 32768;
  localparam int unsigned BLK64_BYTES  = 65536;
  localparam int unsigned OTP_BYTES    = 512;

  // Bit positions and the 64 KB block count derived from the sizes above.
  localparam int unsigned SECTOR_LSB   = $clog2(SECTOR_BYTES);
  localparam int unsigned BLK32_LSB    = $clog2(BLK32_BYTES);
  localparam int unsigned BLK64_LSB    = $clog2(BLK64_BYTES);
  localparam int unsigned BLK64_COUNT  = ARRAY_BYTES / BLK64_BYTES;

  // ----------------------------------------------------------------
  // Link constants and reset values
  // ----------------------------------------------------------------
  localparam int unsigned LANES        = 4;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [7:0]  TX_IDLE_BYTE = 8'hff;
  localparam logic [3:0]  OE_SINGLE    = 4'h2;
  localparam logic [3:0]  OE_DUAL      = 4'h3;
  localparam logic [3:0]  OE_QUAD      = 4'hf;
  localparam logic [3:0]  AREA_ALL_BP  = 4'h6;

  typedef enum logic [1:0] {
    QSFPI_SINGLE = 2'b00,
    QSFPI_DUAL   = 2'b01,
    QSFPI_QUAD   = 2'b10
  } qsfpi_mode_t;

  typedef enum logic [1:0] {
    QSFPI_ER_SECTOR = 2'b00,
    QSFPI_ER_BLK32  = 2'b01,
    QSFPI_ER_BLK64  = 2'b10,
    QSFPI_ER_CHIP   = 2'b11
  } qsfpi_erase_t;

endpackage : qsfpi_pkg

// file: logic/qsfpi_fifo.sv
`timescale 1ns/1ps
module qsfpi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  // The storage is flip-flops, so the head word is already registered.
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  a_fifo_no_overfill: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_q <= (PW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : qsfpi_fifo

// file: logic/qsfpi_core.sv
`timescale 1ns/1ps
module qsfpi_core (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          serial_clk,
  input  wire logic                          chip_sel_n,
  input  wire logic [qsfpi_pkg::LANES-1:0]   data_lane_in,
  output logic      [qsfpi_pkg::LANES-1:0]   data_lane_out,
  output logic      [qsfpi_pkg::LANES-1:0]   data_lane_oe,
  input  wire logic [1:0]                    lane_mode,
  input  wire logic                          tx_phase,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire logic [7:0]                    tx_data,
  output logic                               rx_valid,
  input  wire logic                          rx_ready,
  output logic      [7:0]                    rx_data,
  output logic                               rx_overrun,
  output logic                               selected,
  output logic                               paused,
  output logic                               armed,
  input  wire logic                          cycle_start,
  input  wire logic                          cycle_done,
  output logic                               cycle_busy,
  input  wire logic [3:0]                    area_protect_bits,
  input  wire logic                          status_lock_bit,
  input  wire logic [qsfpi_pkg::ADDR_W-1:0]  target_addr,
  output logic                               status_write_refused,
  output logic                               area_bits_locked,
  output logic                               addr_protected,
  input  wire logic                          prog_data_phase,
  output logic      [8:0]                    prog_count,
  output logic      [7:0]                    page_offset,
  input  wire logic [7:0]                    prog_old_byte,
  output logic      [7:0]                    prog_merged_byte,
  input  wire logic [1:0]                    erase_kind,
  output logic      [qsfpi_pkg::ADDR_W-1:0]  erase_first,
  output logic      [qsfpi_pkg::ADDR_W-1:0]  erase_last,
  input  wire logic                          otp_select,
  input  wire logic                          otp_locked,
  input  wire logic [8:0]                    otp_offset,
  output logic                               otp_prog_refused
);
  import qsfpi_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]       sclk_q;
  logic [1:0]       csn_q;
  logic [LANES-1:0] lane_s1_q;
  logic [LANES-1:0] lane_s2_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_q    <= 3'h0;
      csn_q     <= 2'h3;
      lane_s1_q <= 4'hf;
      lane_s2_q <= 4'hf;
    end else begin
      sclk_q    <= {sclk_q[1:0], serial_clk};
      csn_q     <= {csn_q[0], chip_sel_n};
      lane_s1_q <= data_lane_in;
      lane_s2_q <= lane_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Select, pause and protect pin decoding
  // ----------------------------------------------------------------
  qsfpi_mode_t mode;
  logic        csn_old_q;
  logic        seen_high_q;
  logic        armed_q;
  logic [1:0]  sync_fill_q;

  assign mode = qsfpi_mode_t'(lane_mode);

  wire is_quad   = (mode == QSFPI_QUAD);
  wire is_dual   = (mode == QSFPI_DUAL);
  wire sel_now   = ~csn_q[1];
  wire sel_fall  = csn_old_q & ~csn_q[1];
  wire pause_lvl = ~is_quad & ~lane_s2_q[3];
  wire wp_low    = ~is_quad & ~lane_s2_q[2];
  wire active    = sel_now & armed_q & ~pause_lvl;
  wire clk_rise  = active & sclk_q[1] & ~sclk_q[2];
  wire clk_fall  = active & ~sclk_q[1] & sclk_q[2];

  // Arming needs a high level seen first, so a select held low through
  // reset release cannot start a frame in mid-instruction. The synchroniser
  // shows its reset value for two cycles, so a high there is not trusted.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csn_old_q   <= 1'b1;
      seen_high_q <= 1'b0;
      armed_q     <= 1'b0;
      sync_fill_q <= 2'h0;
    end else begin
      csn_old_q   <= csn_q[1];
      sync_fill_q <= {sync_fill_q[0], 1'b1};
      if (csn_q[1] && sync_fill_q[1]) seen_high_q <= 1'b1;
      if (sel_fall && seen_high_q) armed_q <= 1'b1;
    end
  end

  assign selected = sel_now;
  assign paused   = sel_now & pause_lvl;
  assign armed    = armed_q;

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  logic [7:0] rx_q;
  logic [3:0] rx_cnt_q;
  logic       ovr_q;

  wire [3:0] rx_step  = is_quad ? 4'd4 : (is_dual ? 4'd2 : 4'd1);
  wire [7:0] rx_shift = is_quad ? {rx_q[3:0], lane_s2_q} :
                        is_dual ? {rx_q[5:0], lane_s2_q[1:0]} :
                                  {rx_q[6:0], lane_s2_q[0]};
  wire [3:0] rx_next  = rx_cnt_q + rx_step;
  wire       rx_byte  = clk_rise & ~tx_phase & (rx_next == 4'd8);
  wire       fifo_in_ready;
  wire       rx_push  = rx_byte & fifo_in_ready;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_q     <= 8'h00;
      rx_cnt_q <= 4'h0;
      ovr_q    <= 1'b0;
    end else if (!sel_now) begin
      rx_cnt_q <= 4'h0;
      ovr_q    <= 1'b0;
    end else if (clk_rise && !tx_phase) begin
      rx_q     <= rx_shift;
      rx_cnt_q <= (rx_next == 4'd8) ? 4'h0 : rx_next;
      if (rx_byte && !fifo_in_ready) ovr_q <= 1'b1;
    end
  end

  assign rx_overrun = ovr_q;

  qsfpi_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (rx_byte),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_shift),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  logic [7:0] tx_q;
  logic [3:0] tx_cnt_q;

  wire       tx_load   = clk_fall & tx_phase & (tx_cnt_q == 4'h0);
  wire [7:0] tx_src    = tx_valid ? tx_data : TX_IDLE_BYTE;
  wire [3:0] tx_next   = tx_cnt_q + rx_step;
  wire [7:0] tx_shift  = is_quad ? {tx_q[3:0], 4'h0} :
                         is_dual ? {tx_q[5:0], 2'h0} : {tx_q[6:0], 1'b0};

  assign tx_ready = tx_load;

  // A new byte is fetched on the first falling edge of each byte, which
  // also covers setting three, whose opening falling edge has no data.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_q     <= 8'h00;
      tx_cnt_q <= 4'h0;
    end else if (!sel_now || !tx_phase) begin
      tx_cnt_q <= 4'h0;
    end else if (clk_fall) begin
      tx_q     <= tx_load ? tx_src : tx_shift;
      tx_cnt_q <= (tx_next == 4'd8) ? 4'h0 : tx_next;
    end
  end

  wire [3:0] lane_val = is_quad ? tx_q[7:4] :
                        is_dual ? {2'b00, tx_q[7:6]} : {2'b00, tx_q[7], 1'b0};
  wire [3:0] lane_en  = is_quad ? OE_QUAD : (is_dual ? OE_DUAL : OE_SINGLE);
  wire       drive    = sel_now & ~pause_lvl & tx_phase & (armed_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_lane_out <= 4'h0;
    end else begin
      data_lane_out <= lane_val;
    end
  end

  assign data_lane_oe = drive ? lane_en : 4'h0;

  // ----------------------------------------------------------------
  // Internal cycle tracking
  // ----------------------------------------------------------------
  logic busy_q;

  // Deselect is not an input here, so a started cycle runs to its end.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (cycle_start) begin
      busy_q <= 1'b1;
    end else if (cycle_done) begin
      busy_q <= 1'b0;
    end
  end

  assign cycle_busy = busy_q;

  // ----------------------------------------------------------------
  // Write protection
  // ----------------------------------------------------------------
  function automatic logic area_hit(input logic [ADDR_W-1:0] a, input logic [3:0] bp);
    logic [5:0] blk;
    logic [5:0] span;
    blk  = {1'b0, a[ADDR_W-1:BLK64_LSB]};
    span = 6'd1 << (bp - 4'd1);
    if (bp == 4'h0)             area_hit = 1'b0;
    else if (bp >= AREA_ALL_BP) area_hit = 1'b1;
    else                        area_hit = blk >= (6'(BLK64_COUNT) - span);
  endfunction : area_hit

  assign status_write_refused = wp_low;
  assign area_bits_locked     = wp_low & status_lock_bit;
  assign addr_protected       = area_hit(target_addr, area_protect_bits);

  // ----------------------------------------------------------------
  // Page program, erase ranges and security sector
  // ----------------------------------------------------------------
  logic [8:0] pcnt_q;
  logic [7:0] poff_q;
  logic [7:0] merged_q;

  // The offset wraps inside the page; the count stops at one page.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pcnt_q <= 9'h000;
      poff_q <= 8'h00;
    end else if (!sel_now) begin
      pcnt_q <= 9'h000;
      poff_q <= target_addr[7:0];
    end else if (rx_push && prog_data_phase) begin
      if (pcnt_q != 9'(PAGE_BYTES)) pcnt_q <= pcnt_q + 9'h001;
      poff_q <= poff_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      merged_q <= 8'hff;
    end else begin
      merged_q <= prog_old_byte & rx_data;
    end
  end

  assign prog_count       = pcnt_q;
  assign page_offset      = poff_q;
  assign prog_merged_byte = merged_q;

  function automatic logic [ADDR_W-1:0] erase_mask(input logic [1:0] k);
    unique case (qsfpi_erase_t'(k))
      QSFPI_ER_SECTOR: erase_mask = ADDR_W'(SECTOR_BYTES - 1);
      QSFPI_ER_BLK32:  erase_mask = ADDR_W'(BLK32_BYTES - 1);
      QSFPI_ER_BLK64:  erase_mask = ADDR_W'(BLK64_BYTES - 1);
      QSFPI_ER_CHIP:   erase_mask = ADDR_W'(ARRAY_BYTES - 1);
    endcase
  endfunction : erase_mask

  wire [ADDR_W-1:0] er_mask = erase_mask(erase_kind);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      erase_first <= '0;
      erase_last  <= '0;
    end else begin
      erase_first <= target_addr & ~er_mask;
      erase_last  <= target_addr | er_mask;
    end
  end

  // A locked security sector refuses every program, whatever offset.
  assign otp_prog_refused = otp_select & (otp_locked | (10'(otp_offset) >= 10'(OTP_BYTES)));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_desel_release: assert property (@(posedge clk_sys) disable iff (rst)
    csn_q[1] |-> data_lane_oe == 4'h0) else $error("lanes driven while deselected");

  a_pause_release: assert property (@(posedge clk_sys) disable iff (rst)
    (sel_now && !is_quad && !lane_s2_q[3]) |-> data_lane_oe == 4'h0)
    else $error("lanes driven during pause");

  a_input_phase_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !tx_phase |-> data_lane_oe == 4'h0) else $error("lanes driven in input phase");

  a_single_lane_oe: assert property (@(posedge clk_sys) disable iff (rst)
    (drive && mode == QSFPI_SINGLE) |-> data_lane_oe == 4'h2)
    else $error("single mode must drive lane 1 only");

  a_unarmed_no_rx: assert property (@(posedge clk_sys) disable iff (rst)
    !armed_q |-> !rx_byte) else $error("byte taken before first select");

  a_busy_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (busy_q && !cycle_done && !cycle_start) |=> busy_q)
    else $error("cycle ended without done");

  a_wp_refuses: assert property (@(posedge clk_sys) disable iff (rst)
    (!is_quad && !lane_s2_q[2]) |-> status_write_refused)
    else $error("status write allowed with protect low");

  a_quad_wp_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    is_quad |-> !status_write_refused && !paused) else $error("quad lanes read as control");

  a_page_limit: assert property (@(posedge clk_sys) disable iff (rst)
    prog_count <= 9'd256) else $error("page count above one page");

  a_byte_after_eight: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_rise && !tx_phase && mode == QSFPI_SINGLE && rx_cnt_q == 4'd7) |-> rx_byte)
    else $error("single lane byte not closed after eight bits");

  a_merge_clears: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> (prog_merged_byte & ~$past(prog_old_byte)) == 8'h00)
    else $error("program set a bit");

  c_single_byte: cover property (@(posedge clk_sys) disable iff (rst)
    rx_push && mode == QSFPI_SINGLE);
  c_quad_read: cover property (@(posedge clk_sys) disable iff (rst)
    tx_load && is_quad);
  c_pause_mid: cover property (@(posedge clk_sys) disable iff (rst)
    sel_now && armed_q && pause_lvl);
  c_overrun: cover property (@(posedge clk_sys) disable iff (rst)
    rx_byte && !fifo_in_ready);

endmodule : qsfpi_core

// file: bench/qsfpi_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master model
// ------------------------------------------------------------
module qsfpi_host_model (
  output logic            serial_clk,
  output logic            chip_sel_n,
  output logic      [3:0] lane_host,
  output logic      [3:0] lane_host_oe,
  input  wire logic [3:0] lane_wire
);
  logic [1:0] mode   = 2'h0;
  logic [3:0] raw    = 4'h0;
  logic [3:0] raw_oe = 4'h0;
  logic       idle   = 1'h0;
  logic       wp_n   = 1'h1;
  logic       hold_n = 1'h1;

  // Outside quad the upper lanes always carry the protect and pause levels, so they never float.
  assign lane_host    = (mode == 2'h2) ? raw : {hold_n, wp_n, raw[1:0]};
  assign lane_host_oe = (mode == 2'h2) ? raw_oe : {2'h3, raw_oe[1:0]};

  // Select starts low so that a frame without a fresh falling edge can be tried first.
  initial begin
    serial_clk = 1'h0;
    chip_sel_n = 1'h0;
  end

  function automatic int width_of(input logic [1:0] m);
    return (m == 2'h2) ? 4 : (m == 2'h1) ? 2 : 1;
  endfunction : width_of

  task automatic sel(input logic [1:0] m, input logic s3);
    mode = m;
    idle = s3;
    serial_clk = s3;
    #80 chip_sel_n = 1'h0;
    #80;
  endtask : sel

  task automatic desel();
    serial_clk = idle;
    #80 chip_sel_n = 1'h1;
    raw_oe = 4'h0;
    #80;
  endtask : desel

  task automatic wr(input logic [7:0] b);
    int n;
    n = width_of(mode);
    raw_oe = 4'((1 << n) - 1);
    for (int i = 8 - n; i >= 0; i -= n) begin
      serial_clk = 1'h0;
      raw = 4'((b >> i) & ((1 << n) - 1));
      #80 serial_clk = 1'h1;
      #80;
    end
  endtask : wr

  task automatic rd(output logic [7:0] b);
    int n;
    n = width_of(mode);
    b = 8'h00;
    for (int i = 0; i < 8; i += n) begin
      serial_clk = 1'h0;
      #80;
      b = (n == 1) ? {b[6:0], lane_wire[1]} : 8'((b << n) | (lane_wire & 4'((1 << n) - 1)));
      serial_clk = 1'h1;
      #80;
    end
  endtask : rd
endmodule : qsfpi_host_model

// file: bench/quad_spi_flash_pin_interface_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module quad_spi_flash_pin_interface_bench;
  import qsfpi_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, tx_phase = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0, stall = 1'h0;
  logic cycle_start = 1'h0, cycle_done = 1'h0, status_lock_bit = 1'h0, prog_data_phase = 1'h0;
  logic otp_select = 1'h0, otp_locked = 1'h0, pv = 1'h0;
  logic [1:0]        lane_mode = 2'h0, erase_kind = 2'h0;
  logic [3:0]        area_protect_bits = 4'h0, flt = 4'h5;
  logic [7:0]        tx_data = 8'h00, prog_old_byte = 8'h00, po, pd;
  logic [8:0]        otp_offset = 9'h000;
  logic [ADDR_W-1:0] target_addr = '0;
  logic [31:0]       seed = 32'h13;
  logic [7:0]        exq[$];
  logic [7:0]        exp_rx;
  int                mismatches = 0, n_compared = 0, loads = 0;
  logic serial_clk, chip_sel_n, tx_ready, rx_valid, rx_overrun, selected, paused, armed, cycle_busy;
  logic status_write_refused, area_bits_locked, addr_protected, otp_prog_refused;
  logic [3:0]        data_lane_in, data_lane_out, data_lane_oe, host_v, host_oe;
  logic [7:0]        rx_data, page_offset, prog_merged_byte;
  logic [8:0]        prog_count;
  logic [ADDR_W-1:0] erase_first, erase_last;

  qsfpi_core qsfpi_core_inst (.clk_sys, .rst, .serial_clk, .chip_sel_n, .data_lane_in, .data_lane_out,
    .data_lane_oe, .lane_mode, .tx_phase, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .rx_overrun, .selected, .paused, .armed, .cycle_start, .cycle_done, .cycle_busy, .area_protect_bits,
    .status_lock_bit, .target_addr, .status_write_refused, .area_bits_locked, .addr_protected,
    .prog_data_phase, .prog_count, .page_offset, .prog_old_byte, .prog_merged_byte, .erase_kind,
    .erase_first, .erase_last, .otp_select, .otp_locked, .otp_offset, .otp_prog_refused);
  qsfpi_host_model qsfpi_host_model_inst (.serial_clk, .chip_sel_n, .lane_host(host_v),
    .lane_host_oe(host_oe), .lane_wire(data_lane_in));

  // ------------------------------------------------------------
  // Wires, clock and background traffic
  // ------------------------------------------------------------
  // A lane nobody drives shows a pattern that changes every cycle, so a stale value cannot pass.
  assign data_lane_in = (data_lane_oe & data_lane_out) | (~data_lane_oe & host_oe & host_v)
                      | (~data_lane_oe & ~host_oe & flt);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) flt <= ~flt;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  always @(posedge clk_sys) begin
    #1;
    prog_old_byte = 8'(rnd());
    rx_ready = ~stall & prog_old_byte[0];
  end

  always @(posedge clk_sys) begin
    if (rst === 1'h0 && pv) `CHK(prog_merged_byte, po & pd)
    if (rst === 1'h0 && rx_valid === 1'h1 && rx_ready === 1'h1) begin
      if (exq.size() == 0) `CHK(rx_valid, 1'h0)
      else begin
        exp_rx = exq.pop_front();
        `CHK(rx_data, exp_rx)
      end
    end
    if (rst === 1'h0) `CHK(data_lane_oe & host_oe, 4'h0)
    if (tx_ready === 1'h1) loads++;
    pv <= (rx_valid === 1'h1);
    po <= prog_old_byte;
    pd <= rx_data;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // The expected byte is queued before the last edge, since the device may hand it on first.
  task automatic wrq(input logic [7:0] b, input logic counts);
    if (counts && exq.size() < FIFO_DEPTH) exq.push_back(b);
    qsfpi_host_model_inst.wr(b);
  endtask : wrq

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [7:0] b;
    logic [7:0] e;
    int a;
    int sz;
    step(20);
    rst = 1'h0;
    step(4);
    wrq(8'h5a, 1'h0);
    `CHK(armed, 1'h0)
    qsfpi_host_model_inst.desel();
    for (int s = 0; s < 6; s++) begin
      lane_mode = 2'(s % 3);
      qsfpi_host_model_inst.sel(lane_mode, 1'(s / 3));
      `CHK(armed, 1'h1)
      repeat (3) wrq(8'(rnd()), 1'h1);
      `CHK(data_lane_oe, 4'h0)
      tx_data = 8'(rnd());
      tx_valid = 1'(s != 4);
      e = tx_valid ? tx_data : TX_IDLE_BYTE;
      qsfpi_host_model_inst.raw_oe = 4'h0;
      tx_phase = 1'h1;
      a = loads;
      qsfpi_host_model_inst.rd(b);
      `CHK(b, e)
      `CHK(loads - a, 1)
      `CHK(data_lane_oe, (s % 3 == 2) ? OE_QUAD : (s % 3 == 1) ? OE_DUAL : OE_SINGLE)
      tx_phase = 1'h0;
      qsfpi_host_model_inst.desel();
      step(4);
      `CHK(data_lane_oe, 4'h0)
    end
    for (int s = 0; s < 3; s += 2) begin
      lane_mode = 2'(s);
      qsfpi_host_model_inst.sel(lane_mode, 1'h0);
      qsfpi_host_model_inst.hold_n = 1'h0;
      qsfpi_host_model_inst.wp_n = 1'h0;
      status_lock_bit = 1'h1;
      tx_phase = 1'(s == 0);
      step(4);
      `CHK(paused, 1'(s == 0))
      `CHK(data_lane_oe, 4'h0)
      `CHK(status_write_refused, 1'(s == 0))
      `CHK(area_bits_locked, 1'(s == 0))
      tx_phase = 1'h0;
      wrq(8'(rnd()), 1'(s == 2));
      qsfpi_host_model_inst.hold_n = 1'h1;
      qsfpi_host_model_inst.wp_n = 1'h1;
      wrq(8'(rnd()), 1'h1);
      qsfpi_host_model_inst.desel();
    end
    lane_mode = 2'h2;
    cycle_start = 1'h1;
    step(1);
    cycle_start = 1'h0;
    stall = 1'h1;
    qsfpi_host_model_inst.sel(lane_mode, 1'h1);
    for (int i = 0; i <= FIFO_DEPTH; i++) wrq(8'(rnd()), 1'h1);
    `CHK(rx_overrun, 1'h1)
    stall = 1'h0;
    for (int i = 0; i < 400 && exq.size() > 0; i++) step(1);
    `CHK(exq.size(), 0)
    qsfpi_host_model_inst.desel();
    step(4);
    `CHK(cycle_busy, 1'h1)
    `CHK(rx_overrun, 1'h0)
    cycle_done = 1'h1;
    step(1);
    cycle_done = 1'h0;
    step(1);
    `CHK(cycle_busy, 1'h0)
    a = rnd();
    target_addr = ADDR_W'(a);
    prog_data_phase = 1'h1;
    step(4);
    qsfpi_host_model_inst.sel(lane_mode, 1'h0);
    wrq(8'(rnd()), 1'h1);
    step(4);
    `CHK(prog_count, 9'h001)
    for (int i = 0; i < PAGE_BYTES; i++) wrq(8'(rnd()), 1'h1);
    step(4);
    `CHK(prog_count, 9'h100)
    `CHK(page_offset, 8'(a + PAGE_BYTES + 1))
    qsfpi_host_model_inst.desel();
    prog_data_phase = 1'h0;
    step(4);
    `CHK(prog_count, 9'h000)
    for (int k = 0; k < 4; k++) begin
      erase_kind = 2'(k);
      a = rnd() % ARRAY_BYTES;
      target_addr = ADDR_W'(a);
      step(3);
      sz = (k == 3) ? ARRAY_BYTES : (k == 2) ? BLK64_BYTES : (k == 1) ? BLK32_BYTES : SECTOR_BYTES;
      `CHK(erase_first, ADDR_W'(a / sz * sz))
      `CHK(erase_last, ADDR_W'(a / sz * sz + sz - 1))
    end
    for (int p = 0; p < 8; p++) begin
      area_protect_bits = 4'(p);
      a = (p >= 1 && p <= 5) ? ARRAY_BYTES - (BLK64_BYTES << (p - 1)) - 1 + (p % 2) : rnd() % ARRAY_BYTES;
      target_addr = ADDR_W'(a);
      otp_select = p[0];
      otp_locked = p[1];
      otp_offset = 9'(rnd());
      step(1);
      `CHK(addr_protected, 1'(p >= 6 || p % 2 == 1))
      `CHK(otp_prog_refused, 1'(p[0] & p[1]))
    end
    close_out();
  end
endmodule : quad_spi_flash_pin_interface_bench
